/* File: timer01_pkg.sv */
// Constants and carrier types shared by the timer 0/1 mode control block
package timer01_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] TIMER_MODE_ADDR = 8'h89;
	localparam logic [7:0] TIMER_MODE_RST  = 8'h00;

	// ==========================================================
	// Field positions inside the mode register
	localparam int T1_GATE_BIT = 7;
	localparam int T1_SRC_BIT  = 6;
	localparam int T1_MODE_LSB = 4;
	localparam int T0_GATE_BIT = 3;
	localparam int T0_SRC_BIT  = 2;
	localparam int T0_MODE_LSB = 0;

	// ==========================================================
	// Operating modes
	typedef enum logic [1:0] {
		MODE_13BIT  = 2'h0,
		MODE_16BIT  = 2'h1,
		MODE_8RELOAD = 2'h2,
		MODE_SPLIT  = 2'h3
	} timer_mode_t;

	// ==========================================================
	// Timing: internal time base is the system clock divided by twelve
	localparam int         PRESCALE_DIV   = 12;
	localparam logic [3:0] PRESCALE_LAST  = 4'(PRESCALE_DIV - 1);
	localparam logic [3:0] PRESCALE_RST   = 4'h0;
	localparam int         SYNC_STAGES    = 3;

	// ==========================================================
	// Pin positions in the synchroniser vector
	localparam int PIN_IRQ0 = 0;
	localparam int PIN_IRQ1 = 1;
	localparam int PIN_CNT0 = 2;
	localparam int PIN_CNT1 = 3;
	localparam int PIN_NUM  = 4;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic        pin_gating;
		logic        source_select;
		timer_mode_t mode;
	} timer_cfg_t;

	typedef struct packed {
		logic timer1_count_input;
		logic timer0_count_input;
		logic ext_irq1_pin;
		logic ext_irq0_pin;
	} timer_pins_t;

	typedef struct packed {
		logic timer1_run;
		logic timer0_run;
		logic timer1_clock_scale;
		logic timer0_clock_scale;
	} timer_ctrl_t;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} timer_count_t;

endpackage

/* File: timer01_mode_control.sv */
// Timer 0 and Timer 1 with their shared mode register on the SFR bus
// What this block does
// RULE1 - Timer 1 ungated: counts whenever its run bit is set, pin ignored.
// RULE2 - Timer 1 gated: counts only with run bit set and irq pin 1 high.
// RULE3 - Timer 1 timer function: ticks on internal clock chosen by its scale bit.
// RULE4 - Timer 1 counter function: one step per falling edge on its count pin.
// RULE5 - Timer 1 modes: 00 13-bit, 01 16-bit, 10 8-bit auto-reload.
// RULE6 - Timer 1 mode 11: stopped, count held.
// RULE7 - Timer 0 ungated: counts whenever its run bit is set, pin ignored.
// RULE8 - Timer 0 gated: counts only with run bit set and irq pin 0 high.
// RULE9 - Timer 0 timer function: ticks on internal clock chosen by its scale bit.
// RULE10 - Timer 0 counter function: one step per falling edge on its count pin.
// RULE11 - Timer 0 modes: 00 13-bit, 01 16-bit, 10 8-bit auto-reload.
// RULE12 - Timer 0 mode 11: low and high bytes run as two 8-bit timers.
// RULE13 - 13-bit mode: five low bits prescale into the full high byte.
// RULE14 - Auto-reload: low byte counts, reloads from unchanged high byte.
module timer01_mode_control (
	// Clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   sys_rst,
	// SFR bus
	input  wire logic [7:0]             sfr_addr,
	input  wire logic                   sfr_wr,
	input  wire logic                   sfr_rd,
	input  wire logic [7:0]             sfr_wdata,
	output logic      [7:0]             sfr_rdata,
	// Run and clock-scale bits from neighbouring registers
	input  wire timer01_pkg::timer_ctrl_t ctrl,
	// External pins
	input  wire timer01_pkg::timer_pins_t pins,
	// Counts and overflow pulses
	output timer01_pkg::timer_count_t   timer0_count,
	output timer01_pkg::timer_count_t   timer1_count,
	output logic                        timer0_overflow,
	output logic                        timer1_overflow
);
	import timer01_pkg::*;

	// ==========================================================
	// Pin synchronisers
	logic [PIN_NUM-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
	logic [PIN_NUM-1:0] pin_vec;

	assign pin_vec = pins;

	// Three stages; a level is accepted only once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < PIN_NUM; gi++) begin : g_sync
			always_comb begin
				filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
			end
			always_ff @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst) begin
					s1_q[gi]   <= 1'b1;
					s2_q[gi]   <= 1'b1;
					s3_q[gi]   <= 1'b1;
					filt_q[gi] <= 1'b1;
				end else begin
					s1_q[gi]   <= pin_vec[gi];
					s2_q[gi]   <= s1_q[gi];
					s3_q[gi]   <= s2_q[gi];
					filt_q[gi] <= filt_d[gi];
				end
			end
		end
	endgenerate

	// Falling edges on the count pins, taken on the filtered level
	logic fall0, fall1;
	assign fall0 = filt_q[PIN_CNT0] & ~filt_d[PIN_CNT0]; // RULE10
	assign fall1 = filt_q[PIN_CNT1] & ~filt_d[PIN_CNT1]; // RULE4

	// ==========================================================
	// Mode register
	logic [7:0] mode_q, mode_d;
	logic [7:0] rdata_q, rdata_d;
	logic       hit;

	assign hit = (sfr_addr == TIMER_MODE_ADDR);

	// Unmapped addresses read as zero so a shared read mux can OR buses
	always_comb begin
		mode_d  = mode_q;
		rdata_d = 8'h00;
		if (sfr_wr && hit) begin
			mode_d = sfr_wdata;
		end
		if (sfr_rd && hit) begin
			rdata_d = mode_q;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q  <= TIMER_MODE_RST;
			rdata_q <= 8'h00;
		end else begin
			mode_q  <= mode_d;
			rdata_q <= rdata_d;
		end
	end

	assign sfr_rdata = rdata_q;

	timer_cfg_t cfg0, cfg1;
	assign cfg0 = timer_cfg_t'(mode_q[T0_GATE_BIT:T0_MODE_LSB]);
	assign cfg1 = timer_cfg_t'(mode_q[T1_GATE_BIT:T1_MODE_LSB]);

	// ==========================================================
	// Divide-by-twelve time base
	logic [3:0] pre_q, pre_d;
	logic       tick12;

	assign tick12 = (pre_q == PRESCALE_LAST);

	always_comb begin
		pre_d = tick12 ? PRESCALE_RST : pre_q + 4'h1;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pre_q <= PRESCALE_RST;
		end else begin
			pre_q <= pre_d;
		end
	end

	// ==========================================================
	// Enables and count events
	logic en0, en1, itick0, itick1, inc0, inc1, inc0_hi;

	// Gate pin only matters when pin gating is selected
	assign en0 = ctrl.timer0_run & (~cfg0.pin_gating | filt_q[PIN_IRQ0]); // RULE7 RULE8
	assign en1 = ctrl.timer1_run & (~cfg1.pin_gating | filt_q[PIN_IRQ1]); // RULE1 RULE2

	// Scale bit set runs from the system clock directly, else from the /12 base
	assign itick0 = ctrl.timer0_clock_scale | tick12; // RULE9
	assign itick1 = ctrl.timer1_clock_scale | tick12; // RULE3

	assign inc0 = en0 & (cfg0.source_select ? fall0 : itick0); // RULE9 RULE10
	assign inc1 = en1 & (cfg1.source_select ? fall1 : itick1); // RULE3 RULE4

	// In split mode the upper byte of timer 0 borrows timer 1's run bit
	assign inc0_hi = ctrl.timer1_run & itick0; // RULE12

	// ==========================================================
	// Counters
	timer_count_t c0_q, c0_d, c1_q, c1_d;
	logic         ov0_q, ov0_d, ov1_q, ov1_d, ov1_own;

	always_comb begin
		c0_d    = c0_q;
		c1_d    = c1_q;
		ov0_d   = 1'b0;
		ov1_own = 1'b0;
		ov1_d   = 1'b0;
		// Timer 0
		case (cfg0.mode)
			MODE_13BIT: begin
				if (inc0) begin
					c0_d.lo[4:0] = c0_q.lo[4:0] + 5'h01; // RULE11 RULE13
					if (c0_q.lo[4:0] == 5'h1F) begin
						c0_d.hi = c0_q.hi + 8'h01; // RULE13
						ov0_d   = (c0_q.hi == 8'hFF);
					end
				end
			end
			MODE_16BIT: begin
				if (inc0) begin
					c0_d  = c0_q + 16'h0001; // RULE11
					ov0_d = (c0_q == 16'hFFFF);
				end
			end
			MODE_8RELOAD: begin
				if (inc0) begin
					c0_d.lo = (c0_q.lo == 8'hFF) ? c0_q.hi : c0_q.lo + 8'h01; // RULE11 RULE14
					ov0_d   = (c0_q.lo == 8'hFF);
				end
			end
			MODE_SPLIT: begin
				if (inc0) begin
					c0_d.lo = c0_q.lo + 8'h01; // RULE12
					ov0_d   = (c0_q.lo == 8'hFF);
				end
				if (inc0_hi) begin
					c0_d.hi = c0_q.hi + 8'h01; // RULE12
					ov1_d   = (c0_q.hi == 8'hFF);
				end
			end
			default: begin
				c0_d = c0_q;
			end
		endcase
		// Timer 1
		case (cfg1.mode)
			MODE_13BIT: begin
				if (inc1) begin
					c1_d.lo[4:0] = c1_q.lo[4:0] + 5'h01; // RULE5 RULE13
					if (c1_q.lo[4:0] == 5'h1F) begin
						c1_d.hi = c1_q.hi + 8'h01; // RULE13
						ov1_own = (c1_q.hi == 8'hFF);
					end
				end
			end
			MODE_16BIT: begin
				if (inc1) begin
					c1_d    = c1_q + 16'h0001; // RULE5
					ov1_own = (c1_q == 16'hFFFF);
				end
			end
			MODE_8RELOAD: begin
				if (inc1) begin
					c1_d.lo = (c1_q.lo == 8'hFF) ? c1_q.hi : c1_q.lo + 8'h01; // RULE5 RULE14
					ov1_own = (c1_q.lo == 8'hFF);
				end
			end
			// Stopped: count is simply held
			default: begin
				c1_d = c1_q; // RULE6
			end
		endcase
		// Timer 1 keeps counting while timer 0 is split, but its overflow
		// output is then owned by timer 0's upper byte
		if (cfg0.mode != MODE_SPLIT) begin
			ov1_d = ov1_own;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			c0_q  <= '0;
			c1_q  <= '0;
			ov0_q <= 1'b0;
			ov1_q <= 1'b0;
		end else begin
			c0_q  <= c0_d;
			c1_q  <= c1_d;
			ov0_q <= ov0_d;
			ov1_q <= ov1_d;
		end
	end

	assign timer0_count    = c0_q;
	assign timer1_count    = c1_q;
	assign timer0_overflow = ov0_q;
	assign timer1_overflow = ov1_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_fall1;
		filt_q[PIN_CNT1] ##1 !filt_q[PIN_CNT1];
	endsequence

	sequence s_fall0;
		filt_q[PIN_CNT0] ##1 !filt_q[PIN_CNT0];
	endsequence

	a_t1_ungated_runs: assert property ( // RULE1
		(!cfg1.pin_gating && ctrl.timer1_run && cfg1.mode == MODE_16BIT
		 && !cfg1.source_select && itick1) |=> (c1_q != $past(c1_q)))
		else $error("timer 1 ungated did not count");

	a_t1_gate_blocks: assert property ( // RULE2
		(cfg1.pin_gating && !filt_q[PIN_IRQ1] && cfg1.mode != MODE_8RELOAD)
		|=> (c1_q == $past(c1_q)))
		else $error("timer 1 counted with gate pin low");

	a_t1_tick_source: assert property ( // RULE3
		(en1 && !cfg1.source_select && !ctrl.timer1_clock_scale && !tick12)
		|-> !inc1)
		else $error("timer 1 stepped off the divided clock");

	a_t1_pin_edge: assert property ( // RULE4
		(en1 && cfg1.source_select) ##0 s_fall1 |-> $past(inc1))
		else $error("timer 1 missed a count pin fall");

	a_t1_mode16_step: assert property ( // RULE5
		(inc1 && cfg1.mode == MODE_16BIT) |=> (c1_q == $past(c1_q) + 16'h0001))
		else $error("timer 1 16-bit step wrong");

	a_t1_stopped_hold: assert property ( // RULE6
		(cfg1.mode == MODE_SPLIT) [*2] |-> (c1_q == $past(c1_q)))
		else $error("timer 1 moved while stopped");

	a_t0_ungated_runs: assert property ( // RULE7
		(!cfg0.pin_gating && ctrl.timer0_run && !cfg0.source_select && itick0)
		|-> inc0)
		else $error("timer 0 ungated did not step");

	a_t0_gate_blocks: assert property ( // RULE8
		(cfg0.pin_gating && !filt_q[PIN_IRQ0]) |-> !inc0)
		else $error("timer 0 stepped with gate pin low");

	a_t0_pin_edge: assert property ( // RULE10
		(en0 && cfg0.source_select) ##0 s_fall0 |-> $past(inc0))
		else $error("timer 0 missed a count pin fall");

	a_t0_reload_val: assert property ( // RULE14
		(inc0 && cfg0.mode == MODE_8RELOAD && c0_q.lo == 8'hFF)
		|=> (c0_q.lo == $past(c0_q.hi)) && timer0_overflow)
		else $error("timer 0 reload wrong");

	a_t0_prescale13: assert property ( // RULE13
		(inc0 && cfg0.mode == MODE_13BIT && c0_q.lo[4:0] != 5'h1F)
		|=> (c0_q.hi == $past(c0_q.hi)))
		else $error("timer 0 high byte stepped early");

	a_t0_split_hi: assert property ( // RULE12
		(cfg0.mode == MODE_SPLIT && inc0_hi && !inc0)
		|=> (c0_q.hi == $past(c0_q.hi) + 8'h01) && (c0_q.lo == $past(c0_q.lo)))
		else $error("timer 0 split high byte wrong");

endmodule

/* File: test_timer01_mode_control.sv */
// Self-checking bench for the timer 0/1 mode control block
`define CHECK(act, exp, msg) begin \
	samples_checked++; \
	if ((act) !== (exp)) begin \
		fail_count++; \
		$display("mismatch at %0t: %s", $time, msg); \
	end \
end

module test_timer01_mode_control;
	timeunit 1ns;
	timeprecision 1ps;
	import timer01_pkg::*;

	// ==========================================================
	// Stimulus and observed signals
	logic         clk_sys;
	logic         sys_rst;
	logic [7:0]   sfr_addr;
	logic         sfr_wr;
	logic         sfr_rd;
	logic [7:0]   sfr_wdata;
	logic [7:0]   sfr_rdata;
	timer_ctrl_t  ctrl;
	timer_pins_t  pins;
	timer_count_t timer0_count;
	timer_count_t timer1_count;
	logic         timer0_overflow;
	logic         timer1_overflow;
	int           fail_count;
	int           samples_checked;
	int           cycle_count;
	int           ovf0_seen;
	int           ovf1_seen;
	logic [7:0]   rd_val;

	timer01_mode_control i_timer01_mode_control (
		.clk_sys         (clk_sys),
		.sys_rst         (sys_rst),
		.sfr_addr        (sfr_addr),
		.sfr_wr          (sfr_wr),
		.sfr_rd          (sfr_rd),
		.sfr_wdata       (sfr_wdata),
		.sfr_rdata       (sfr_rdata),
		.ctrl            (ctrl),
		.pins            (pins),
		.timer0_count    (timer0_count),
		.timer1_count    (timer1_count),
		.timer0_overflow (timer0_overflow),
		.timer1_overflow (timer1_overflow)
	);

	// ==========================================================
	// Clock, overflow tally and hang guard
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Overflows are one-cycle pulses; each is looked at mid-cycle, where it has settled
	always @(negedge clk_sys) begin
		cycle_count++;
		if (timer0_overflow === 1'b1) ovf0_seen++;
		if (timer1_overflow === 1'b1) ovf1_seen++;
		if (cycle_count == 20000) begin
			fail_count++;
			stop_test();
		end
	end

	// ==========================================================
	// Shared tasks; all start and end at a falling edge
	task automatic stop_test();
		if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Counts are not writable, so each scenario starts from reset
	task automatic do_reset();
		sys_rst = 1'b1;
		repeat (3) @(negedge clk_sys);
		sys_rst = 1'b0;
		ovf0_seen = 0;
		ovf1_seen = 0;
		@(negedge clk_sys);
	endtask

	task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
		sfr_addr = addr;
		sfr_wdata = data;
		sfr_wr = 1'b1;
		@(negedge clk_sys);
		sfr_wr = 1'b0;
		// Idle cycle so a following call never re-raises the strobe in the same step
		@(negedge clk_sys);
	endtask

	task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
		sfr_addr = addr;
		sfr_rd = 1'b1;
		@(negedge clk_sys);
		sfr_rd = 1'b0;
		data = sfr_rdata;
		@(negedge clk_sys);
	endtask

	// Run bits at r1 and r0 for exactly n edges, then let the counts settle
	task automatic run_for(input logic r1, input logic r0, input int n);
		ctrl.timer1_run = r1;
		ctrl.timer0_run = r0;
		repeat (n) @(negedge clk_sys);
		ctrl.timer1_run = 1'b0;
		ctrl.timer0_run = 1'b0;
		repeat (4) @(negedge clk_sys);
	endtask

	task automatic check_counts(input logic [15:0] e0, input logic [15:0] e1);
		`CHECK(timer0_count, e0, "timer 0 count")
		`CHECK(timer1_count, e1, "timer 1 count")
	endtask

	// ==========================================================
	// Scenarios
	task automatic test_register();
		do_reset();
		sfr_read(8'h89, rd_val);
		`CHECK(rd_val, TIMER_MODE_RST, "mode register reset value")
		sfr_write(8'h89, 8'hA5);
		sfr_write(8'h8A, 8'hFF);
		sfr_read(8'h89, rd_val);
		`CHECK(rd_val, 8'hA5, "mode register read back")
		sfr_read(8'h8A, rd_val);
		`CHECK(rd_val, 8'h00, "unmapped read")
	endtask

	// Both timers in one mode, fast time base, from a zero count
	task automatic test_mode(input logic [7:0] cfg, input int n, input logic [15:0] e,
			input int ovf);
		do_reset();
		sfr_write(TIMER_MODE_ADDR, cfg);
		run_for(1'b1, 1'b1, n);
		check_counts(e, e);
		`CHECK(ovf0_seen, ovf, "timer 0 overflow pulses")
		`CHECK(ovf1_seen, ovf, "timer 1 overflow pulses")
	endtask

	task automatic test_split();
		do_reset();
		sfr_write(TIMER_MODE_ADDR, 8'h33);
		run_for(1'b0, 1'b1, 300);
		check_counts(16'h002C, 16'h0000);
		`CHECK(ovf0_seen, 1, "split low byte overflow")
		`CHECK(ovf1_seen, 0, "split high byte overflow")
		run_for(1'b1, 1'b0, 10);
		check_counts(16'h0A2C, 16'h0000);
	endtask

	// Irq pins need a few edges to pass the input filter
	task automatic test_gate();
		do_reset();
		sfr_write(TIMER_MODE_ADDR, 8'h99);
		pins.ext_irq0_pin = 1'b0;
		pins.ext_irq1_pin = 1'b0;
		repeat (6) @(negedge clk_sys);
		run_for(1'b1, 1'b1, 20);
		check_counts(16'h0000, 16'h0000);
		pins.ext_irq0_pin = 1'b1;
		pins.ext_irq1_pin = 1'b1;
		repeat (6) @(negedge clk_sys);
		run_for(1'b1, 1'b1, 20);
		check_counts(16'h0014, 16'h0014);
		sfr_write(TIMER_MODE_ADDR, 8'h11);
		pins.ext_irq0_pin = 1'b0;
		pins.ext_irq1_pin = 1'b0;
		repeat (6) @(negedge clk_sys);
		run_for(1'b1, 1'b1, 20);
		check_counts(16'h0028, 16'h0028);
		pins.ext_irq0_pin = 1'b1;
		pins.ext_irq1_pin = 1'b1;
	endtask

	// Any 120 consecutive edges hold exactly ten divided ticks
	task automatic test_prescale();
		do_reset();
		sfr_write(TIMER_MODE_ADDR, 8'h11);
		ctrl.timer1_clock_scale = 1'b0;
		ctrl.timer0_clock_scale = 1'b0;
		run_for(1'b1, 1'b1, 120);
		check_counts(16'h000A, 16'h000A);
		ctrl.timer1_clock_scale = 1'b1;
		ctrl.timer0_clock_scale = 1'b1;
	endtask

	// Counter function: internal ticks must not leak into the count
	task automatic test_counter();
		do_reset();
		sfr_write(TIMER_MODE_ADDR, 8'h55);
		ctrl.timer1_run = 1'b1;
		ctrl.timer0_run = 1'b1;
		repeat (5) begin
			pins.timer0_count_input = 1'b0;
			pins.timer1_count_input = 1'b0;
			repeat (4) @(negedge clk_sys);
			pins.timer0_count_input = 1'b1;
			pins.timer1_count_input = 1'b1;
			repeat (4) @(negedge clk_sys);
		end
		run_for(1'b0, 1'b0, 8);
		check_counts(16'h0005, 16'h0005);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		fail_count = 0;
		samples_checked = 0;
		cycle_count = 0;
		sys_rst = 1'b1;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
		ctrl = 4'h3;
		pins = 4'hF;
		@(negedge clk_sys);
		test_register();
		test_mode(8'h11, 300, 16'h012C, 0);
		test_mode(8'h00, 40, 16'h0108, 0);
		test_mode(8'h22, 260, 16'h0004, 1);
		test_split();
		test_gate();
		test_prescale();
		test_counter();
		stop_test();
	end
endmodule
